// ---- logic/scs_pkg.sv ----
// Constants for the card interface select and synchronous framing block
//
// Behaviour
// - Route field 00 none, 01 external slot, 1X internal slot.
// - Route field steers the UART, card clock and I/O line to a slot; it never powers a slot.
// - Bypass set: UART cut off, I/O line from card control data/direction.
// - Sync: direct line flag 1 uses control bits at count limit or zero; flag 0 or a running count uses transmit FIFO bits.
// - Line start/stop mode bit (the direct line flag) sits at bit 7 of transmit control.
// - Bit-length counter counts falling clock edges to loaded 1..255, interrupts, needs reload.
// - Release from high drops clock at once; from low, half period low first.
package scs_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [15:0] SCS_SEL_ADDR    = 16'hFE00;
    localparam logic [15:0] SCS_INT_ADDR    = 16'hFE01;
    localparam logic [15:0] SCS_MASK_ADDR   = 16'hFE02;
    localparam logic [15:0] SCS_SUPPLY_ADDR = 16'hFE03;
    localparam logic [15:0] SCS_TXCTL_ADDR  = 16'hFE04;
    localparam logic [15:0] SCS_ICTL_ADDR   = 16'hFE05;
    localparam logic [15:0] SCS_ECTL_ADDR   = 16'hFE06;
    localparam logic [15:0] SCS_RLEN_ADDR   = 16'hFE07;
    localparam logic [15:0] SCS_DIV_ADDR    = 16'hFE08;
    localparam logic [15:0] SCS_MODE_ADDR   = 16'hFE09;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int SCS_SEL_ROUTE_LO = 2;
    localparam int SCS_SEL_BYPASS   = 1;
    localparam int SCS_TX_STARTSTOP = 7;
    localparam int SCS_TX_MODE      = 0;
    localparam int SCS_CTL_DATA     = 0;
    localparam int SCS_CTL_DIR      = 1;
    localparam int SCS_CTL_STOP     = 2;
    localparam int SCS_CTL_LEVEL    = 3;
    localparam int SCS_CTL_SAMPLE   = 5;
    localparam int SCS_INT_RLEN     = 7;
    localparam int SCS_INT_IOFALL   = 4;
    localparam int SCS_SUP_INT      = 0;
    localparam int SCS_SUP_EXT      = 1;
    localparam int SCS_MODE_SYNC    = 0;
    // ---------------------------------------------------------------
    // Reset values and masks
    // ---------------------------------------------------------------
    localparam logic [7:0] SCS_SEL_RST   = 8'h00;
    localparam logic [7:0] SCS_SEL_MASK  = 8'h0E;
    localparam logic [7:0] SCS_CTL_RST   = 8'h04;
    localparam logic [7:0] SCS_CTL_WMASK = 8'h0F;
    localparam logic [7:0] SCS_DIV_RST   = 8'h04;
    localparam logic [7:0] SCS_ZERO      = 8'h00;
endpackage : scs_pkg

// ---- logic/scs_select_sync.sv ----
// Card interface select, bypass and synchronous clock/bit-length logic
//
// Decided for this implementation: strobed register access.
module scs_select_sync
    import scs_pkg::*;
#(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Register port
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    output logic             irq_o,
    // Card UART side
    input  wire logic        uart_tx_i,
    input  wire logic        uart_tx_en_i,
    output logic             uart_rx_o,
    input  wire logic        fifo_bit_i,
    output logic             fifo_shift_o,
    // Slot supply enables
    output logic             int_active_o,
    output logic             ext_active_o,
    // Internal slot pins
    output logic             int_clk_o,
    input  wire logic        int_io_i,
    output logic             int_io_o,
    output logic             int_io_oe_n_o,
    // External slot pins
    output logic             ext_clk_o,
    input  wire logic        external_card_io_i,
    output logic             external_card_io_o,
    output logic             external_card_io_oe_n_o
);
    if (DIV_W < 2 || DIV_W > 8) begin : g_chk
        $error("DIV_W must lie in 2..8");
    end

    // ---------------------------------------------------------------
    // Reset release and pin synchronisers
    // ---------------------------------------------------------------
    logic       rst_s1_ff, rst_ff;
    logic [1:0] iio_s_ff, eio_s_ff;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_ff <= 1'b0;
            rst_ff    <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_ff    <= rst_s1_ff;
        end
    end
    always_ff @(posedge clk_i or negedge rst_ff) begin
        if (!rst_ff) begin
            iio_s_ff <= 2'h3;
            eio_s_ff <= 2'h3;
        end else begin
            iio_s_ff <= {iio_s_ff[0], int_io_i};
            eio_s_ff <= {eio_s_ff[0], external_card_io_i};
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [7:0] sel_ff, int_ff, mask_ff, sup_ff, txctl_ff, ictl_ff, ectl_ff;
    logic [7:0] rlen_max_ff, rlen_cnt_ff, div_ff, mode_ff;
    logic       io_prev_ff, clk_ff, run_ff;
    logic [DIV_W-1:0] div_cnt_ff;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
        return a == r;
    endfunction : hit

    wire wr_sel  = wr_i && hit(addr_i, SCS_SEL_ADDR);
    wire wr_mask = wr_i && hit(addr_i, SCS_MASK_ADDR);
    wire wr_sup  = wr_i && hit(addr_i, SCS_SUPPLY_ADDR);
    wire wr_tx   = wr_i && hit(addr_i, SCS_TXCTL_ADDR);
    wire wr_ictl = wr_i && hit(addr_i, SCS_ICTL_ADDR);
    wire wr_ectl = wr_i && hit(addr_i, SCS_ECTL_ADDR);
    wire wr_rlen = wr_i && hit(addr_i, SCS_RLEN_ADDR);
    wire wr_div  = wr_i && hit(addr_i, SCS_DIV_ADDR);
    wire wr_mode = wr_i && hit(addr_i, SCS_MODE_ADDR);
    wire rd_int  = rd_i && hit(addr_i, SCS_INT_ADDR);

    wire [1:0] route   = sel_ff[SCS_SEL_ROUTE_LO+1:SCS_SEL_ROUTE_LO];
    wire       sel_int = route[1];
    wire       sel_ext = (route == 2'b01);
    wire       bypass  = sel_ff[SCS_SEL_BYPASS];
    wire       sync_on = mode_ff[SCS_MODE_SYNC];
    wire [7:0] cur_ctl = sel_int ? ictl_ff : ectl_ff;
    wire       stop    = cur_ctl[SCS_CTL_STOP];
    wire       level   = cur_ctl[SCS_CTL_LEVEL];
    wire       cur_io  = sel_int ? iio_s_ff[1] : eio_s_ff[1];
    wire       any_sel = sel_int | sel_ext;

    // ---------------------------------------------------------------
    // Card clock generator
    // ---------------------------------------------------------------
    wire [DIV_W-1:0] half     = (div_ff[DIV_W-1:0] == '0) ? DIV_W'(1) : div_ff[DIV_W-1:0];
    wire             term     = (div_cnt_ff >= half - DIV_W'(1));
    wire             clk_run  = sync_on && any_sel;
    // release from high drops the clock at once
    wire             restart  = clk_run && !run_ff && !stop;
    wire             rel_high = restart && clk_ff;
    // Stop only at a phase boundary so no half period is truncated
    wire             halt     = run_ff && term && stop && (clk_ff == level);
    wire             toggle   = run_ff && term && !halt;
    wire             fall_evt = (toggle && clk_ff) || rel_high;
    wire             rise_evt = toggle && !clk_ff;

    always_ff @(posedge clk_i or negedge rst_ff) begin
        if (!rst_ff) begin
            clk_ff     <= 1'b0;
            run_ff     <= 1'b0;
            div_cnt_ff <= '0;
        end else if (!clk_run) begin
            run_ff     <= 1'b0;
            div_cnt_ff <= '0;
        end else if (restart) begin
            run_ff     <= 1'b1;
            clk_ff     <= 1'b0;
            div_cnt_ff <= '0;
        end else if (halt) begin
            run_ff     <= 1'b0;
        end else if (toggle) begin
            clk_ff     <= ~clk_ff;
            div_cnt_ff <= '0;
        end else if (run_ff) begin
            div_cnt_ff <= div_cnt_ff + DIV_W'(1);
        end
    end

    // ---------------------------------------------------------------
    // Bit-length counter
    // ---------------------------------------------------------------
    // The fall made by a release from high is itself the skipped edge,
    // so it must be caught in the same cycle, not remembered for later
    wire skip_now   = rel_high && (rlen_cnt_ff == SCS_ZERO);
    wire rlen_armed = (rlen_max_ff != SCS_ZERO) && (rlen_cnt_ff != rlen_max_ff);
    wire rlen_done  = sync_on && rlen_armed && fall_evt && !skip_now
                      && (rlen_cnt_ff + 8'h01 == rlen_max_ff);
    // count falling edges up to the loaded value
    always_ff @(posedge clk_i or negedge rst_ff) begin
        if (!rst_ff) begin
            rlen_max_ff <= SCS_ZERO;
            rlen_cnt_ff <= SCS_ZERO;
        end else if (wr_rlen) begin
            rlen_max_ff <= wdata_i;
            rlen_cnt_ff <= SCS_ZERO;
        end else if (fall_evt && sync_on && rlen_armed && !skip_now) begin
            rlen_cnt_ff <= rlen_cnt_ff + 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // I/O line source
    // ---------------------------------------------------------------
    // direct control at count limit or zero when the flag is set
    wire rlen_idle  = (rlen_max_ff == SCS_ZERO) || (rlen_cnt_ff == rlen_max_ff);
    wire line_flag  = txctl_ff[SCS_TX_STARTSTOP];
    // bypass hands the line to the card control bits
    wire direct     = bypass || (sync_on && rlen_idle && line_flag);
    wire tx_mode    = txctl_ff[SCS_TX_MODE];
    wire nxt_io     = direct ? cur_ctl[SCS_CTL_DATA] : sync_on ? fifo_bit_i : uart_tx_i;
    wire nxt_drive  = direct ? cur_ctl[SCS_CTL_DIR] : sync_on ? tx_mode : uart_tx_en_i;
    wire io_fall    = bypass && io_prev_ff && !cur_io;
    wire nxt_shift  = sync_on && !direct && fall_evt && !skip_now;

    // ---------------------------------------------------------------
    // Register writes and interrupt status
    // ---------------------------------------------------------------
    logic [7:0] set_bits;
    assign set_bits = ({7'h00, rlen_done} << SCS_INT_RLEN)
                    | ({7'h00, io_fall} << SCS_INT_IOFALL);

    always_ff @(posedge clk_i or negedge rst_ff) begin
        if (!rst_ff) begin
            sel_ff     <= SCS_SEL_RST;
            int_ff     <= SCS_ZERO;
            mask_ff    <= SCS_ZERO;
            sup_ff     <= SCS_ZERO;
            txctl_ff   <= SCS_ZERO;
            ictl_ff    <= SCS_CTL_RST;
            ectl_ff    <= SCS_CTL_RST;
            div_ff     <= SCS_DIV_RST;
            mode_ff    <= SCS_ZERO;
            io_prev_ff <= 1'b1;
        end else begin
            io_prev_ff <= cur_io;
            // reserved select bits dropped on write
            if (wr_sel)  sel_ff   <= wdata_i & SCS_SEL_MASK;
            if (wr_mask) mask_ff  <= wdata_i;
            if (wr_sup)  sup_ff   <= wdata_i & 8'h03;
            // start/stop mode bit held at bit 7
            if (wr_tx)   txctl_ff <= wdata_i & 8'h81;
            if (wr_div)  div_ff   <= wdata_i;
            if (wr_mode) mode_ff  <= wdata_i & 8'h01;
            // Event set wins over the read clear
            int_ff <= (rd_int ? SCS_ZERO : int_ff) | set_bits;
            if (wr_ictl) ictl_ff[3:0] <= wdata_i[3:0];
            if (wr_ectl) ectl_ff[3:0] <= wdata_i[3:0];
            if (rise_evt && sel_int) ictl_ff[SCS_CTL_SAMPLE] <= iio_s_ff[1];
            if (rise_evt && sel_ext) ectl_ff[SCS_CTL_SAMPLE] <= eio_s_ff[1];
        end
    end

    // ---------------------------------------------------------------
    // Read data and registered outputs
    // ---------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        case (addr_i)
            SCS_SEL_ADDR:    rd_mux = sel_ff;
            SCS_INT_ADDR:    rd_mux = int_ff;
            SCS_MASK_ADDR:   rd_mux = mask_ff;
            SCS_SUPPLY_ADDR: rd_mux = sup_ff;
            SCS_TXCTL_ADDR:  rd_mux = txctl_ff;
            SCS_ICTL_ADDR:   rd_mux = ictl_ff & 8'h2F;
            SCS_ECTL_ADDR:   rd_mux = ectl_ff & 8'h2F;
            SCS_RLEN_ADDR:   rd_mux = rlen_cnt_ff;
            SCS_DIV_ADDR:    rd_mux = div_ff;
            SCS_MODE_ADDR:   rd_mux = mode_ff;
            default:         rd_mux = SCS_ZERO;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_ff) begin
        if (!rst_ff) begin
            rdata_o                 <= SCS_ZERO;
            irq_o                   <= 1'b0;
            uart_rx_o               <= 1'b1;
            fifo_shift_o            <= 1'b0;
            int_active_o            <= 1'b0;
            ext_active_o            <= 1'b0;
            int_clk_o               <= 1'b0;
            ext_clk_o               <= 1'b0;
            int_io_o                <= 1'b1;
            int_io_oe_n_o           <= 1'b1;
            external_card_io_o      <= 1'b1;
            external_card_io_oe_n_o <= 1'b1;
        end else begin
            rdata_o                 <= rd_i ? rd_mux : SCS_ZERO;
            irq_o                   <= |(((rd_int ? SCS_ZERO : int_ff) | set_bits) & mask_ff);
            uart_rx_o               <= (any_sel && !bypass) ? cur_io : 1'b1;
            fifo_shift_o            <= nxt_shift;
            // slot power follows the supply register only
            int_active_o            <= sup_ff[SCS_SUP_INT];
            ext_active_o            <= sup_ff[SCS_SUP_EXT];
            int_clk_o               <= sel_int && clk_ff;
            ext_clk_o               <= sel_ext && clk_ff;
            int_io_o                <= sel_int ? nxt_io : 1'b1;
            int_io_oe_n_o           <= !(sel_int && nxt_drive);
            external_card_io_o      <= sel_ext ? nxt_io : 1'b1;
            external_card_io_oe_n_o <= !(sel_ext && nxt_drive);
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    route_none_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        route == 2'b00 |=> int_io_oe_n_o && external_card_io_oe_n_o && !int_clk_o)
        else $error("unselected slot driven");
    route_ext_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        sel_ext |=> !int_clk_o && int_io_oe_n_o)
        else $error("internal slot driven while external selected");
    supply_sep_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        wr_sel && !wr_sup |=> int_active_o == $past(sup_ff[SCS_SUP_INT]))
        else $error("select write changed slot power");
    bypass_line_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        bypass && sel_int |=> int_io_o == $past(ictl_ff[SCS_CTL_DATA])
                              && int_io_oe_n_o == !$past(ictl_ff[SCS_CTL_DIR]))
        else $error("bypass line not from control bits");
    fifo_line_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        sync_on && sel_ext && !direct |=> external_card_io_o == $past(fifo_bit_i))
        else $error("sync line not from transmit FIFO");
    fifo_int_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        sync_on && sel_int && !direct |=> int_io_o == $past(fifo_bit_i))
        else $error("internal line not from transmit FIFO");
    direct_int_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        sync_on && sel_int && line_flag && (rlen_cnt_ff == rlen_max_ff)
        |=> int_io_o == $past(ictl_ff[SCS_CTL_DATA]))
        else $error("direct line flag ignored at count limit");
    rlen_skip_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        sync_on && rel_high && rlen_cnt_ff == SCS_ZERO && !wr_rlen |=> rlen_cnt_ff == SCS_ZERO)
        else $error("release fall counted as a bit");
    flag_bit_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        wr_tx |=> line_flag == $past(wdata_i[7]))
        else $error("start/stop mode bit not at bit 7");
    rlen_int_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        rlen_done |=> int_ff[SCS_INT_RLEN] && rlen_cnt_ff == rlen_max_ff ##1
                      (rlen_cnt_ff == rlen_max_ff || $past(wr_rlen)))
        else $error("bit-length counter did not stop at loaded value");
    rlen_hold_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        !rlen_armed && !wr_rlen |=> $stable(rlen_cnt_ff))
        else $error("bit-length counter moved without reload");
    release_high_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        rel_high |=> !clk_ff ##0 run_ff)
        else $error("clock not dropped on release from high");
    release_low_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        restart && !clk_ff |=> !clk_ff [*2])
        else $error("clock rose before half period low");
    sel_rsvd_a: assert property (@(posedge clk_i) disable iff (!rst_ff)
        1'b1 |-> (sel_ff & ~SCS_SEL_MASK) == SCS_ZERO)
        else $error("reserved select bits set");
endmodule : scs_select_sync

// ---- sim/scs_card_model.sv ----
// Card model for one slot: open-drain I/O line with a pull-up
module scs_card_model (
    // Device side of the pin
    input  wire logic io_dev_i,
    input  wire logic io_oe_n_i,
    // Card pulls the line low when the bench asks
    input  wire logic drv_low_i,
    // Resolved line level
    output logic      line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released line floats to the pull-up level, never a stale value
    assign line_o = (io_oe_n_i | io_dev_i) & ~drv_low_i;
endmodule : scs_card_model

// ---- sim/tb_top.sv ----
// Testbench for the card select and synchronous framing block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import scs_pkg::*;
    localparam int HALF  = 3;
    localparam int LIMIT = 20000;
    logic        clk, rst_n, wr, rd, tx, tx_en, fifo_bit, int_drv, ext_drv;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata_o, v;
    logic        irq_o, uart_rx_o, fifo_shift_o, int_active_o, ext_active_o;
    logic        int_clk_o, int_io_o, int_io_oe_n_o, int_line;
    logic        ext_clk_o, external_card_io_o, external_card_io_oe_n_o, ext_line;
    int          n_errors, cmp_count, cyc, n;
    int          shift_cnt = 0;
    // ---------------------------------------------------------------
    // Design and card models
    // ---------------------------------------------------------------
    scs_select_sync #(.DIV_W(8)) scs_select_sync_i (
        .clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata_o), .irq_o(irq_o), .uart_tx_i(tx),
        .uart_tx_en_i(tx_en), .uart_rx_o(uart_rx_o), .fifo_bit_i(fifo_bit),
        .fifo_shift_o(fifo_shift_o), .int_active_o(int_active_o),
        .ext_active_o(ext_active_o), .int_clk_o(int_clk_o), .int_io_i(int_line),
        .int_io_o(int_io_o), .int_io_oe_n_o(int_io_oe_n_o), .ext_clk_o(ext_clk_o),
        .external_card_io_i(ext_line), .external_card_io_o(external_card_io_o),
        .external_card_io_oe_n_o(external_card_io_oe_n_o));
    scs_card_model scs_card_model_i (.io_dev_i(int_io_o), .io_oe_n_i(int_io_oe_n_o),
        .drv_low_i(int_drv), .line_o(int_line));
    scs_card_model scs_card_model_ext_i (.io_dev_i(external_card_io_o),
        .io_oe_n_i(external_card_io_oe_n_o), .drv_low_i(ext_drv), .line_o(ext_line));
    // ---------------------------------------------------------------
    // Clock, reset values and hang limit
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        rst_n = 0; addr = 0; wdata = 0; wr = 0; rd = 0; tx = 1; tx_en = 0;
        fifo_bit = 1; int_drv = 0; ext_drv = 0; n_errors = 0; cmp_count = 0; cyc = 0;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors++;
            end_of_test();
        end
    end
    // Transmit FIFO advance pulses seen so far
    always @(posedge clk) begin
        if (fifo_shift_o === 1'b1) shift_cnt <= shift_cnt + 1;
    end
    // ---------------------------------------------------------------
    // Register port tasks and checks
    // ---------------------------------------------------------------
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata_o;
    endtask : rd_reg
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic chk_rd(input logic [15:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rd_reg(a, d);
        chk(nm, e, d);
    endtask : chk_rd
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : settle
    // Cycles until the internal slot clock shows level lv, at most lim
    task automatic wait_lvl(input logic lv, input int lim, output int k);
        k = 0;
        #1;
        while (int_clk_o !== lv && k < lim) begin
            settle(1);
            k++;
        end
    endtask : wait_lvl
    // Firmware start (stp=0) or stop (stp=1) bit, then clock release checks
    task automatic fw_bit(input bit stp);
        int k0;
        rd_reg(SCS_INT_ADDR, v);
        wr_reg(SCS_ICTL_ADDR, 8'h0F);
        if (stp) wr_reg(SCS_ICTL_ADDR, 8'h0E);
        wr_reg(SCS_TXCTL_ADDR, 8'h81);
        wr_reg(SCS_RLEN_ADDR, 8'h03);
        wr_reg(SCS_ICTL_ADDR, stp ? 8'h0F : 8'h0E);
        wait_lvl(1'b1, 4 * HALF, n);
        settle(3 * HALF);
        chk("clk_held_high", 8'h01, int_clk_o);
        k0 = shift_cnt;
        wr_reg(SCS_ICTL_ADDR, stp ? 8'h03 : 8'h02);
        wait_lvl(1'b0, 4, n);
        chk("fall_at_once", 8'h01, n <= 2);
        wait_lvl(1'b1, 4 * HALF, n);
        chk("low_half", 8'(HALF), 8'(n));
        wait_lvl(1'b0, 4 * HALF, n);
        chk("high_half", 8'(HALF), 8'(n));
        // Release fall is skipped, so only the later fall counts and shifts
        chk_rd(SCS_RLEN_ADDR, 8'h01, "rlen_skip");
        chk("fifo_shift", 8'h01, 8'(shift_cnt - k0));
    endtask : fw_bit
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk_rd(SCS_SEL_ADDR, SCS_SEL_RST, "sel_reset");
        chk_rd(SCS_DIV_ADDR, SCS_DIV_RST, "div_reset");
        wr_reg(SCS_SEL_ADDR, 8'hFF);
        chk_rd(SCS_SEL_ADDR, SCS_SEL_MASK, "sel_reserved");
        chk_rd(16'hFE0F, SCS_ZERO, "unmapped");
        @(posedge clk);
        tx_en <= 1'b1; tx <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            wr_reg(SCS_SEL_ADDR, 8'(c << SCS_SEL_ROUTE_LO));
            settle(3);
            chk("ext_io", (c == 1) ? 8'h00 : 8'h01, external_card_io_o);
            chk("ext_oe_n", (c == 1) ? 8'h00 : 8'h01, external_card_io_oe_n_o);
            chk("int_io", (c >= 2) ? 8'h00 : 8'h01, int_io_o);
            chk("active", 8'h00, {int_active_o, ext_active_o});
        end
        wr_reg(SCS_SUPPLY_ADDR, 8'h03);
        settle(2);
        chk("active_on", 8'h03, {ext_active_o, int_active_o});
        // Internal slot line is low from the UART, and the UART hears it back
        chk("uart_rx_int", 8'h00, uart_rx_o);
        // Bypass: falling I/O edge raises, masks and clears the event
        tx <= 1'b1;
        wr_reg(SCS_SEL_ADDR, 8'h0A);
        wr_reg(SCS_MASK_ADDR, 8'h10);
        rd_reg(SCS_INT_ADDR, v);
        int_drv <= 1'b1;
        settle(8);
        chk("irq_bypass", 8'h01, irq_o);
        chk("uart_rx_cut", 8'h01, uart_rx_o);
        chk_rd(SCS_INT_ADDR, 8'h10, "status_fall");
        settle(1);
        chk("irq_cleared", 8'h00, irq_o);
        wr_reg(SCS_MASK_ADDR, 8'h00);
        int_drv <= 1'b0;
        settle(4);
        int_drv <= 1'b1;
        settle(8);
        chk("irq_masked", 8'h00, irq_o);
        chk_rd(SCS_INT_ADDR, 8'h10, "status_masked");
        int_drv <= 1'b0;
        wr_reg(SCS_ICTL_ADDR, 8'h02);
        settle(3);
        chk("byp_io", 8'h00, {int_io_oe_n_o, int_io_o});
        wr_reg(SCS_ICTL_ADDR, 8'h01);
        settle(3);
        chk("byp_dir_in", 8'h01, int_io_oe_n_o);
        // Synchronous mode, bit length of three from a low stop
        wr_reg(SCS_SEL_ADDR, 8'h08);
        wr_reg(SCS_ICTL_ADDR, 8'h06);
        wr_reg(SCS_MODE_ADDR, 8'h01);
        wr_reg(SCS_DIV_ADDR, 8'(HALF));
        wr_reg(SCS_TXCTL_ADDR, 8'h81);
        wr_reg(SCS_MASK_ADDR, 8'h80);
        rd_reg(SCS_INT_ADDR, v);
        wr_reg(SCS_RLEN_ADDR, 8'h03);
        wr_reg(SCS_ICTL_ADDR, 8'h02);
        wait_lvl(1'b1, 4 * HALF, n);
        chk("low_first", 8'h01, n >= HALF && n <= HALF + 2);
        for (int i = 0; i < 200 && irq_o !== 1'b1; i++) settle(1);
        chk("irq_rlen", 8'h01, irq_o);
        chk_rd(SCS_RLEN_ADDR, 8'h03, "rlen_count");
        settle(10 * HALF);
        chk_rd(SCS_RLEN_ADDR, 8'h03, "rlen_held");
        chk_rd(SCS_INT_ADDR, 8'h80, "status_rlen");
        chk("ext_clk_idle", 8'h00, ext_clk_o);
        chk("direct_io", 8'h00, {int_io_oe_n_o, int_io_o});
        wr_reg(SCS_TXCTL_ADDR, 8'h01);
        settle(3);
        chk("fifo_io_hi", 8'h01, int_io_o);
        @(posedge clk);
        fifo_bit <= 1'b0;
        wr_reg(SCS_ICTL_ADDR, 8'h03);
        settle(3);
        chk("fifo_io_lo", 8'h00, int_io_o);
        fw_bit(1'b0);
        fw_bit(1'b1);
        end_of_test();
    end
endmodule : tb_top
